// [design/oovfr_seq.sv]
// Output overvoltage fault response sequencer with its configuration byte
// Functional notes
// - Every response class pulls the alert line low and sets the fault status bit.
// - Class 00 keeps the output regulating with no interruption.
// - Class 01 runs on for the time field delay, then acts per retry field if the fault stays.
// - Class 10 disables the output at once, then restarts per retry field.
// - Class 11 holds the output off while the fault lasts and re-enables it after.
// - Retry 000 makes no restart; output stays off until the fault is cleared.
// - Retry 001..110 allows one to six restarts, then stays off until cleared.
// - Retry 111 restarts without limit until commanded off, bias loss or another fault.
// - Run-on delay is the time field times 10 ms.
// - Restart spacing is the time field times 8.2 ms, start to start.
// - Configuration is a read-write byte at command code 0x41.
module oovfr_seq (
  input  wire logic                 sys_clk,     // System clock, 125 MHz
  input  wire logic                 rstn,        // Synchronous reset, active low
  input  wire oovfr_pkg::oovfr_bus_t bus,        // Register write strobe, code, data
  input  wire logic [7:0]           rdCode,      // Register read code
  output logic [7:0]                rdData,      // Register read data
  output logic                      rdHit,       // Read code is mapped
  input  wire logic                 faultClear,  // Host fault clear pulse
  input  wire logic                 ovFaultPin,  // Overvoltage comparator, asynchronous
  input  wire logic                 enableCmd,   // Output commanded on
  input  wire logic                 biasOk,      // Bias power good
  input  wire logic                 otherFault,  // Another fault shut the output
  output logic                      outputEn,    // Power stage enable
  output logic                      ovStatus,    // Sticky fault status bit
  output logic                      alertIn,     // fault_alert_line input (unused)
  output logic                      alertOut,    // fault_alert_line drive value (low)
  output logic                      alertOe      // fault_alert_line drive enable
);
  logic [7:0]             cfg;
  logic [7:0]             next_cfg;
  logic [2:0]             syncSh;
  logic                   fault;
  logic                   next_fault;
  logic                   faultPrev;
  oovfr_pkg::oovfr_state_t state;
  oovfr_pkg::oovfr_state_t next_state;
  logic [2:0]             tries;
  logic [2:0]             next_tries;
  logic                   next_ovStatus;
  logic                   next_outputEn;
  logic                   runStart;
  logic                   tryStart;
  logic                   runDone;
  logic                   tryDone;
  logic                   stopRetry;
  logic                   newFault;
  logic [1:0]             resp;
  logic [2:0]             retry;

  // Field decode used in several places
  function automatic logic [2:0] fld3(input logic [7:0] v, input int lo);
    fld3 = 3'(v >> lo);
  endfunction : fld3

  assign resp  = cfg[oovfr_pkg::RESP_HI:oovfr_pkg::RESP_LO];
  assign retry = fld3(cfg, oovfr_pkg::RETRY_LO);

  // Configuration byte write and read back
  always_comb begin
    next_cfg = cfg;
    if (bus.wr && bus.code == oovfr_pkg::CFG_CODE) begin
      next_cfg = bus.data;
    end
  end
  assign rdHit  = (rdCode == oovfr_pkg::CFG_CODE);
  assign rdData = rdHit ? cfg : 8'h00;

  // Fault input filter: updates only when stages two and three agree
  always_comb begin
    next_fault = fault;
    if (syncSh[1] == syncSh[2]) begin
      next_fault = syncSh[2];
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      cfg       <= oovfr_pkg::CFG_RESET;
      syncSh    <= 3'h0;
      fault     <= 1'b0;
      faultPrev <= 1'b0;
    end else begin
      cfg       <= next_cfg;
      syncSh    <= {syncSh[1:0], ovFaultPin};
      fault     <= next_fault;
      faultPrev <= fault;
    end
  end

  assign newFault  = fault && !faultPrev;
  assign stopRetry = !enableCmd || !biasOk || otherFault;

  // Run-on timer, 10 ms per unit
  oovfr_unit_timer #(.UNIT_CYC(oovfr_pkg::RUN_UNIT_CYC)) runTmr (
    .sys_clk (sys_clk),
    .rstn    (rstn),
    .start   (runStart),
    .units   (fld3(cfg, oovfr_pkg::TIME_LO)),
    .done    (runDone)
  );

  // Restart spacing timer, 8.2 ms per unit
  oovfr_unit_timer #(.UNIT_CYC(oovfr_pkg::RETRY_UNIT_CYC)) tryTmr (
    .sys_clk (sys_clk),
    .rstn    (rstn),
    .start   (tryStart),
    .units   (fld3(cfg, oovfr_pkg::TIME_LO)),
    .done    (tryDone)
  );

  // Sequencer; status set wins over a clear in the same cycle
  always_comb begin
    next_state    = state;
    next_tries    = tries;
    next_outputEn = outputEn;
    next_ovStatus = ovStatus;
    runStart      = 1'b0;
    tryStart      = 1'b0;
    if (faultClear) begin
      next_ovStatus = 1'b0;
    end
    if (newFault) begin
      next_ovStatus = 1'b1;
    end
    case (state)
      oovfr_pkg::ST_IDLE: begin
        next_outputEn = enableCmd && biasOk && !otherFault;
        if (newFault) begin
          next_tries = 3'h0;
          case (resp)
            oovfr_pkg::RESP_IGNORE: next_state = oovfr_pkg::ST_IDLE;
            oovfr_pkg::RESP_DELAY: begin
              runStart   = 1'b1;
              next_state = oovfr_pkg::ST_RUN;
            end
            oovfr_pkg::RESP_RETRY: begin
              next_outputEn = 1'b0;
              tryStart      = 1'b1;
              next_state    = oovfr_pkg::ST_WAIT;
            end
            default: begin
              next_outputEn = 1'b0;
              next_state    = oovfr_pkg::ST_HOLD;
            end
          endcase
        end
      end
      oovfr_pkg::ST_RUN: begin
        if (!fault) begin
          next_state = oovfr_pkg::ST_IDLE;
        end else if (runDone && !runStart) begin
          next_outputEn = 1'b0;
          tryStart      = 1'b1;
          next_state    = oovfr_pkg::ST_WAIT;
        end
      end
      oovfr_pkg::ST_WAIT: begin
        // Attempt spacing counts from the start of the previous attempt
        if (retry == oovfr_pkg::RETRY_NONE) begin
          next_state = oovfr_pkg::ST_LATCH;
        end else if (retry == oovfr_pkg::RETRY_FOREVER && stopRetry) begin
          next_state = oovfr_pkg::ST_LATCH;
        end else if (tryDone && !tryStart) begin
          if (retry != oovfr_pkg::RETRY_FOREVER && tries == retry) begin
            next_state = oovfr_pkg::ST_LATCH;
          end else begin
            next_tries    = (retry == oovfr_pkg::RETRY_FOREVER) ? tries : tries + 3'h1;
            next_outputEn = 1'b1;
            tryStart      = 1'b1;
            next_state    = oovfr_pkg::ST_TRY;
          end
        end
      end
      oovfr_pkg::ST_TRY: begin
        // Attempt fails when the fault returns before the spacing ends
        if (fault) begin
          next_outputEn = 1'b0;
          next_state    = oovfr_pkg::ST_WAIT;
        end else if (tryDone) begin
          next_state = oovfr_pkg::ST_IDLE;
        end
      end
      oovfr_pkg::ST_LATCH: begin
        next_outputEn = 1'b0;
        if (faultClear && !fault) begin
          next_state = oovfr_pkg::ST_IDLE;
        end
      end
      oovfr_pkg::ST_HOLD: begin
        next_outputEn = 1'b0;
        if (!fault) begin
          next_state = oovfr_pkg::ST_IDLE;
        end
      end
      default: next_state = oovfr_pkg::ST_IDLE;
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      state    <= oovfr_pkg::ST_IDLE;
      tries    <= 3'h0;
      outputEn <= 1'b0;
      ovStatus <= 1'b0;
    end else begin
      state    <= next_state;
      tries    <= next_tries;
      outputEn <= next_outputEn;
      ovStatus <= next_ovStatus;
    end
  end

  // Open-drain alert: only ever pulls low
  assign alertOut = 1'b0;
  assign alertOe  = ovStatus;
  assign alertIn  = 1'b0;
endmodule : oovfr_seq

// [design/oovfr_unit_timer.sv]
// Unit timer: counts a number of time units, each a fixed cycle count
module oovfr_unit_timer #(
  parameter int UNIT_CYC = 1250000
) (
  input  wire logic       sys_clk, // System clock
  input  wire logic       rstn,    // Synchronous reset, active low
  input  wire logic       start,   // Restart the count from zero
  input  wire logic [2:0] units,   // Number of units to run
  output logic            done     // Level: count finished
);
  logic [20:0] cyc;
  logic [20:0] next_cyc;
  logic [2:0]  cnt;
  logic [2:0]  next_cnt;
  logic        next_done;

  // Next count; a zero unit count finishes at once
  always_comb begin
    next_cyc  = cyc;
    next_cnt  = cnt;
    next_done = done;
    if (start) begin
      next_cyc  = '0;
      next_cnt  = '0;
      next_done = (units == 3'h0);
    end else if (!done) begin
      if (cyc == 21'(UNIT_CYC - 1)) begin
        next_cyc = '0;
        next_cnt = cnt + 3'h1;
        if (cnt + 3'h1 == units) begin
          next_done = 1'b1;
        end
      end else begin
        next_cyc = cyc + 21'h1;
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      cyc  <= '0;
      cnt  <= '0;
      done <= 1'b1;
    end else begin
      cyc  <= next_cyc;
      cnt  <= next_cnt;
      done <= next_done;
    end
  end
endmodule : oovfr_unit_timer

// [inc/oovfr_pkg.sv]
// Package: register code, field layout, timing constants and types of the OV fault sequencer
package oovfr_pkg;
  // Command code of the response configuration byte
  localparam logic [7:0] CFG_CODE      = 8'h41;
  localparam logic [7:0] CFG_RESET     = 8'h80;
  // Field positions inside the configuration byte
  localparam int         RESP_HI       = 7;
  localparam int         RESP_LO       = 6;
  localparam int         RETRY_HI      = 5;
  localparam int         RETRY_LO      = 3;
  localparam int         TIME_HI       = 2;
  localparam int         TIME_LO       = 0;
  // Response classes
  localparam logic [1:0] RESP_IGNORE   = 2'h0;
  localparam logic [1:0] RESP_DELAY    = 2'h1;
  localparam logic [1:0] RESP_RETRY    = 2'h2;
  localparam logic [1:0] RESP_HOLD     = 2'h3;
  // Retry field special values
  localparam logic [2:0] RETRY_NONE    = 3'h0;
  localparam logic [2:0] RETRY_FOREVER = 3'h7;
  // Timing: units in microseconds, clock in MHz
  localparam int         CLK_MHZ       = 125;
  localparam int         RUN_UNIT_US   = 10000;
  localparam int         RETRY_UNIT_US = 8200;
  localparam int         RUN_UNIT_CYC  = RUN_UNIT_US * CLK_MHZ;
  localparam int         RETRY_UNIT_CYC = RETRY_UNIT_US * CLK_MHZ;

  // Sequencer states, Gray coded along the main path
  typedef enum logic [2:0] {
    ST_IDLE  = 3'b000,
    ST_RUN   = 3'b001,
    ST_WAIT  = 3'b011,
    ST_TRY   = 3'b010,
    ST_LATCH = 3'b110,
    ST_HOLD  = 3'b111
  } oovfr_state_t;

  // Register access strobe group
  typedef struct packed {
    logic       wr;
    logic [7:0] code;
    logic [7:0] data;
  } oovfr_bus_t;
endpackage : oovfr_pkg

// [test/oovfr_host.sv]
// Host model: writes and reads the response byte, issues fault clears
module oovfr_host (
  input  wire logic             sys_clk,    // System clock
  output oovfr_pkg::oovfr_bus_t bus,        // Write group
  output logic [7:0]            rdCode,     // Read code
  output logic                  faultClear  // Clear pulse
);
  timeunit 1ns;
  timeprecision 100ps;
  initial begin
    bus = '0;
    rdCode = 8'h41;
    faultClear = 1'b0;
  end
  // Strobe stands one edge; code and data flipped after so stale values never match
  task automatic put(input logic [7:0] code, input logic [7:0] data);
    @(negedge sys_clk);
    bus <= '{wr: 1'b1, code: code, data: data};
    @(negedge sys_clk);
    bus <= '{wr: 1'b0, code: ~code, data: ~data};
  endtask : put
  task automatic look(input logic [7:0] code);
    @(negedge sys_clk);
    rdCode <= code;
  endtask : look
  task automatic clr();
    @(negedge sys_clk);
    faultClear <= 1'b1;
    @(negedge sys_clk);
    faultClear <= 1'b0;
  endtask : clr
endmodule : oovfr_host

// [test/oovfr_props.sv]
// Checker: port-level properties of the OV fault sequencer
module oovfr_props (
  input wire logic                  sys_clk,    // Clock
  input wire logic                  rstn,       // Sync reset, low
  input wire oovfr_pkg::oovfr_bus_t bus,        // Write group
  input wire logic [7:0]            rdCode,     // Read code
  input wire logic [7:0]            rdData,     // Read data
  input wire logic                  rdHit,      // Read hit
  input wire logic                  faultClear, // Clear pulse
  input wire logic                  enableCmd,  // Output on
  input wire logic                  biasOk,     // Bias good
  input wire logic                  otherFault, // Other fault
  input wire logic                  outputEn,   // Stage enable
  input wire logic                  ovStatus,   // Status bit
  input wire logic                  alertOut,   // Alert value
  input wire logic                  alertOe     // Alert enable
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rstn);

  // Open-drain alert only ever pulls low, and only with the status bit
  alert_drive_a: assert property (alertOe == ovStatus && !alertOut)
    else $error("alert drive differs from status bit");
  map_hit_a: assert property (rdHit == (rdCode == 8'h41))
    else $error("read hit wrong for code");
  map_miss_a: assert property (!rdHit |-> rdData == 8'h00)
    else $error("unmapped read not zero");
  cfg_write_a: assert property (bus.wr && bus.code == 8'h41
    |=> !rdHit || rdData == $past(bus.data))
    else $error("written byte not read back");
  status_keep_a: assert property (ovStatus && !faultClear |=> ovStatus)
    else $error("status bit dropped without clear");
  // Class read through the read port, so the bench keeps the code parked there
  ignore_run_a: assert property ($rose(ovStatus) && rdHit && rdData[7:6] == 2'h0
    && outputEn |=> outputEn[*4])
    else $error("ignore class interrupted output");
  retry_off_a: assert property ($rose(ovStatus) && rdHit && rdData[7:6] == 2'h2
    |-> ##[0:1] !outputEn)
    else $error("disable class left output on");
  en_cause_a: assert property ($rose(outputEn)
    |-> $past(enableCmd && biasOk && !otherFault))
    else $error("output restarted without enable");

  cov_ignore: cover property ($rose(ovStatus) && rdData[7:6] == 2'h0);
  cov_retry: cover property ($rose(ovStatus) && rdData[7:6] == 2'h2);
  cov_miss: cover property (!rdHit);
endmodule : oovfr_props

bind oovfr_seq oovfr_props props (.sys_clk(sys_clk), .rstn(rstn), .bus(bus),
  .rdCode(rdCode), .rdData(rdData), .rdHit(rdHit), .faultClear(faultClear),
  .enableCmd(enableCmd), .biasOk(biasOk), .otherFault(otherFault),
  .outputEn(outputEn), .ovStatus(ovStatus), .alertOut(alertOut), .alertOe(alertOe));

// [test/tb.sv]
// Testbench: fault classes, retry limits and the response byte
module tb;
  timeunit 1ns;
  timeprecision 100ps;
  logic                  sys_clk = 1'b0;
  logic                  rstn = 1'b0;
  oovfr_pkg::oovfr_bus_t bus;
  logic [7:0]            rdCode, rdData;
  logic                  rdHit, faultClear, outputEn, ovStatus, alertOut, alertOe;
  logic                  ovFaultPin = 1'b0;
  logic                  enableCmd = 1'b1;
  logic                  biasOk = 1'b1;
  logic                  otherFault = 1'b0;
  int                    n_fail = 0;
  int                    n_checks = 0;
  int                    cyc = 0;

  oovfr_host host (.sys_clk(sys_clk), .bus(bus), .rdCode(rdCode), .faultClear(faultClear));
  oovfr_seq dut (.sys_clk(sys_clk), .rstn(rstn), .bus(bus), .rdCode(rdCode),
    .rdData(rdData), .rdHit(rdHit), .faultClear(faultClear), .ovFaultPin(ovFaultPin),
    .enableCmd(enableCmd), .biasOk(biasOk), .otherFault(otherFault), .outputEn(outputEn),
    .ovStatus(ovStatus), .alertIn(), .alertOut(alertOut), .alertOe(alertOe));

  initial begin
    forever #4 sys_clk = ~sys_clk;
  end
  // Hang guard: a few hundred cycles expected
  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 3000) begin
      n_fail++;
      stop_test();
    end
  end

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  // Pin change then a fixed settle covering the 3-4 cycle filter
  task automatic fault(input logic lvl);
    @(negedge sys_clk);
    ovFaultPin = lvl;
    repeat (8) @(negedge sys_clk);
  endtask : fault
  task automatic stop_test();
    $display("checks %0d fails %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : stop_test

  task automatic t_regs();
    chk(rdData, 8'h80);
    chk(8'({alertOe, ovStatus, outputEn}), 8'h01);
    host.put(8'h41, 8'h5a);
    chk(rdData, 8'h5a);
    host.put(8'h40, 8'h00);
    chk(rdData, 8'h5a);
    host.look(8'h40);
    @(negedge sys_clk);
    chk(8'(rdHit), 8'h00);
    chk(rdData, 8'h00);
    host.look(8'h41);
    $display("register test done");
  endtask : t_regs
  // Time field 0 keeps delays at zero so the run stays short; 8'h41 has time 1, its 10 ms run-on outlasts the fault
  task automatic t_class(input logic [7:0] cfg, input logic offF, input logic offL);
    host.put(8'h41, cfg);
    fault(1'b1);
    chk(8'({alertOe, alertOut, ovStatus}), 8'h05);
    chk(8'(outputEn), 8'(!offF));
    fault(1'b0);
    chk(8'(outputEn), 8'(!offL));
    chk(8'(ovStatus), 8'h01);
    host.clr();
    repeat (3) @(negedge sys_clk);
    chk(8'({ovStatus, outputEn}), 8'h01);
    $display("class test %h done", cfg);
  endtask : t_class
  // Fault held through every attempt: count restarts, then expect latched off
  task automatic t_limit(input logic [7:0] cfg, input logic [7:0] nExp);
    int   nRise;
    logic prev;
    nRise = 0;
    host.put(8'h41, cfg);
    prev = outputEn;
    @(negedge sys_clk);
    ovFaultPin = 1'b1;
    repeat (30) begin
      @(negedge sys_clk);
      if (outputEn && !prev) begin
        nRise++;
      end
      prev = outputEn;
    end
    chk(8'(nRise), nExp);
    chk(8'(outputEn), 8'h00);
    fault(1'b0);
    chk(8'(outputEn), 8'h00);
    host.clr();
    repeat (3) @(negedge sys_clk);
    chk(8'(outputEn), 8'h01);
    $display("retry limit test %h done", cfg);
  endtask : t_limit
  // Endless retry ends on one of the three stop causes
  task automatic t_endless(input int cause);
    host.put(8'h41, 8'hb8);
    fault(1'b1);
    case (cause)
      0: enableCmd = 1'b0;
      1: biasOk = 1'b0;
      default: otherFault = 1'b1;
    endcase
    fault(1'b0);
    enableCmd = 1'b1;
    biasOk = 1'b1;
    otherFault = 1'b0;
    repeat (4) @(negedge sys_clk);
    chk(8'(outputEn), 8'h00);
    host.clr();
    repeat (3) @(negedge sys_clk);
    chk(8'(outputEn), 8'h01);
    $display("endless retry test %0d done", cause);
  endtask : t_endless

  initial begin
    repeat (5) @(negedge sys_clk);
    rstn = 1'b1;
    repeat (2) @(negedge sys_clk);
    t_regs();
    t_class(8'h00, 1'b0, 1'b0);
    t_class(8'h40, 1'b1, 1'b1);
    t_class(8'h41, 1'b0, 1'b0);
    t_class(8'h80, 1'b1, 1'b1);
    t_class(8'hc0, 1'b1, 1'b0);
    t_limit(8'h90, 8'h02);
    t_limit(8'hb0, 8'h06);
    t_endless(0);
    t_endless(1);
    t_endless(2);
    stop_test();
  end
endmodule : tb
